// [include/prog_store_pkg.sv]
// package for the program store module: widths, reset values, bus structs
// assumes one 50 MHz clock and a synchronous active-high reset
package prog_store_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MOD_W = 6;
  localparam int unsigned PC_W = 10;
  localparam int unsigned STORE_WORDS = 1024;
  localparam int unsigned STACK_DEPTH = 4;
  localparam int unsigned PHASES = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [7:0] BUS_IDLE = 8'h00;
  // module numbers are fixed when the store is programmed; values arbitrary
  localparam logic [MOD_W-1:0] MEM_MOD_BASE = 6'h00;
  localparam logic [MOD_W-1:0] PORT_A_MOD = 6'h30;
  localparam logic [MOD_W-1:0] PORT_B_MOD = 6'h31;

  typedef struct packed {
    logic transfer_direction;        // 1 = read towards processor
    logic data_or_address_qualifier; // 1 = data word, 0 = intra-module index
    logic counter_select;            // 1 = program counter, 0 = indirect register
    logic [1:0] return_stack_control; // 00 none, 01 push, 10 pop, 11 advance
  } bus_ctrl_s;

  typedef struct packed {
    logic [DATA_W-1:0] out;
    logic [DATA_W-1:0] oe;
  } pin_drive_s;
endpackage

// [rtl/program_store_module.sv]
// program store module: 1k x 8 store, program counter on a four-deep stack,
// two open-drain 8-bit latched ports, answering on the shared data bus.
// assumes bus pins arrive asynchronous and are resolved outside this module.
`timescale 1ns/1ps

module program_store_module (
  input wire logic clk_in, // system clock
  input wire logic srst_in, // synchronous reset, active high
  input wire logic clk_en_in, // freezes all state when low
  input wire logic [7:0] data_bus_in, // shared_data_bus sensed level
  output logic [7:0] data_bus_out, // shared_data_bus pull value
  output logic [7:0] data_bus_oe_out, // shared_data_bus pull enable per bit
  input wire logic [5:0] module_number_bus_in, // module number
  input wire prog_store_pkg::bus_ctrl_s ctrl_in, // processor control lines
  input wire logic [7:0] port_a_in, // port a pin levels
  output logic [7:0] port_a_out, // port a pull value
  output logic [7:0] port_a_oe_out, // port a pull enable
  input wire logic [7:0] port_b_in, // port b pin levels
  output logic [7:0] port_b_out, // port b pull value
  output logic [7:0] port_b_oe_out, // port b pull enable
  output logic [9:0] pc_out // current program counter
);

  typedef struct packed {
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    logic [5:0] mod_s1;
    logic [5:0] mod_s2;
    prog_store_pkg::bus_ctrl_s ctrl_s1;
    prog_store_pkg::bus_ctrl_s ctrl_s2;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pb_s1;
    logic [7:0] pb_s2;
    logic [1:0] phase;
    logic [9:0] ind_addr;
    logic [3:0][9:0] stack;
    logic [7:0] latch_a;
    logic [7:0] latch_b;
    prog_store_pkg::pin_drive_s bus_drv;
    prog_store_pkg::pin_drive_s pa_drv;
    prog_store_pkg::pin_drive_s pb_drv;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // contents set when programmed; zero until a mask image is supplied
  logic [7:0] store_mem [0:prog_store_pkg::STORE_WORDS-1];
  always_comb begin
    for (int i = 0; i < prog_store_pkg::STORE_WORDS; i++) begin
      store_mem[i] = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic mem_hit;
  logic pa_hit;
  logic pb_hit;
  logic [9:0] fetch_addr;
  logic [7:0] fetch_word;
  logic drive_phase;
  prog_store_pkg::bus_ctrl_s c;

  always_comb begin
    c = st_ff.ctrl_s2;
    // upper four module bits select the 1k store, base fixed at programming
    mem_hit = (st_ff.mod_s2[5:2] == prog_store_pkg::MEM_MOD_BASE[5:2]);
    pa_hit = (st_ff.mod_s2 == prog_store_pkg::PORT_A_MOD);
    pb_hit = (st_ff.mod_s2 == prog_store_pkg::PORT_B_MOD);
    // low two module bits extend the 8-bit word index to 10 bits
    fetch_addr = c.counter_select ? st_ff.stack[0] : st_ff.ind_addr;
    fetch_word = store_mem[fetch_addr];
    drive_phase = (st_ff.phase == prog_store_pkg::PHASE_LAST);
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.data_s1 = data_bus_in;
    nxt_st.data_s2 = st_ff.data_s1;
    nxt_st.mod_s1 = module_number_bus_in;
    nxt_st.mod_s2 = st_ff.mod_s1;
    nxt_st.ctrl_s1 = ctrl_in;
    nxt_st.ctrl_s2 = st_ff.ctrl_s1;
    nxt_st.pa_s1 = port_a_in;
    nxt_st.pa_s2 = st_ff.pa_s1;
    nxt_st.pb_s1 = port_b_in;
    nxt_st.pb_s2 = st_ff.pb_s1;
    nxt_st.phase = st_ff.phase + 2'h1;
    nxt_st.bus_drv.out = prog_store_pkg::BUS_IDLE;
    nxt_st.bus_drv.oe = 8'h00;

    if (drive_phase) begin
      // stack and address updates once per machine cycle, at its end
      if (mem_hit) begin
        case (c.return_stack_control)
          2'b01: begin
            for (int i = prog_store_pkg::STACK_DEPTH - 1; i > 0; i--) begin
              nxt_st.stack[i] = st_ff.stack[i-1];
            end
            nxt_st.stack[0] = {st_ff.mod_s2[1:0], st_ff.data_s2};
          end
          2'b10: begin
            for (int i = 0; i < prog_store_pkg::STACK_DEPTH - 1; i++) begin
              nxt_st.stack[i] = st_ff.stack[i+1];
            end
          end
          2'b11: nxt_st.stack[0] = st_ff.stack[0] + 10'h001;
          default: ;
        endcase
        if (!c.data_or_address_qualifier) begin
          if (c.counter_select) begin
            nxt_st.stack[0] = {st_ff.mod_s2[1:0], st_ff.data_s2};
          end else begin
            nxt_st.ind_addr = {st_ff.mod_s2[1:0], st_ff.data_s2};
          end
        end
      end
      // port writes latch the word; write 1 to release a line for input
      if (c.data_or_address_qualifier && !c.transfer_direction) begin
        if (pa_hit) begin
          nxt_st.latch_a = st_ff.data_s2;
        end else if (pb_hit) begin
          nxt_st.latch_b = st_ff.data_s2;
        end
      end
    end else if (st_ff.phase == 2'h2 && c.transfer_direction && c.data_or_address_qualifier) begin
      // precharged bus: pull only the zero bits, in the drive phase only
      if (mem_hit) begin
        nxt_st.bus_drv.oe = ~fetch_word;
      end else if (pa_hit) begin
        nxt_st.bus_drv.oe = ~(st_ff.pa_s2 & st_ff.latch_a);
      end else if (pb_hit) begin
        nxt_st.bus_drv.oe = ~(st_ff.pb_s2 & st_ff.latch_b);
      end
    end

    // open drain: pull low where latch holds 0, otherwise float
    nxt_st.pa_drv.out = 8'h00;
    nxt_st.pa_drv.oe = ~nxt_st.latch_a;
    nxt_st.pb_drv.out = 8'h00;
    nxt_st.pb_drv.oe = ~nxt_st.latch_b;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_ff <= '0;
      st_ff.stack <= {prog_store_pkg::STACK_DEPTH{prog_store_pkg::PC_RESET}};
      st_ff.latch_a <= prog_store_pkg::PORT_RESET;
      st_ff.latch_b <= prog_store_pkg::PORT_RESET;
    end else if (clk_en_in) begin
      st_ff <= nxt_st;
    end
  end

  assign data_bus_out = st_ff.bus_drv.out;
  assign data_bus_oe_out = st_ff.bus_drv.oe;
  assign port_a_out = st_ff.pa_drv.out;
  assign port_a_oe_out = st_ff.pa_drv.oe;
  assign port_b_out = st_ff.pb_drv.out;
  assign port_b_oe_out = st_ff.pb_drv.oe;
  assign pc_out = st_ff.stack[0];

endmodule

// [testbench/proc_bus_model.sv]
// processor-side model of the precharged shared data bus
// assumes the design only pulls lines low through its enables
`timescale 1ns/1ps
module proc_bus_model (
  input wire logic drv_in, // processor drives a word
  input wire logic [7:0] val_in, // word driven
  input wire logic [7:0] oe_in, // design pull enables
  output logic [7:0] bus_out // resolved bus level
);
  // precharged high; every party can only pull low, so wired-and
  assign bus_out = (drv_in ? val_in : 8'hff) & ~oe_in;
endmodule

// [testbench/program_store_module_tb.sv]
// self-checking bench for the program store module
// assumes the processor bus model and the bound checker
`timescale 1ns/1ps
module program_store_module_tb;
  localparam logic [4:0] RD = 5'h18, AD_PC = 5'h04, AD_IX = 5'h00, WR = 5'h08, PUSH = 5'h05, POP = 5'h02;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [5:0] mod_nb = 6'h20;
  prog_store_pkg::bus_ctrl_s ctrl = '0;
  logic [7:0] wval = 8'hff, ext_a = 8'hff, seen, bus, oe, pa_oe, pb_oe;
  logic [9:0] pc;
  int n_mismatch = 0;
  int compares = 0;
  always #10 clk_in = ~clk_in;
  proc_bus_model bus_u (.drv_in(~ctrl.transfer_direction), .val_in(wval), .oe_in(oe), .bus_out(bus));
  program_store_module dut_u (.clk_in, .srst_in, .clk_en_in(1'b1), .data_bus_in(bus), .data_bus_out(),
    .data_bus_oe_out(oe), .module_number_bus_in(mod_nb), .ctrl_in(ctrl), .port_a_in(ext_a & ~pa_oe),
    .port_a_out(), .port_a_oe_out(pa_oe), .port_b_in(~pb_oe), .port_b_out(), .port_b_oe_out(pb_oe), .pc_out(pc));
  ////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  // one machine cycle of request, then idle; idle module matches nothing
  task automatic op(input logic [5:0] m, input logic [4:0] c, input logic [7:0] v);
    seen = 8'h00;
    @(negedge clk_in);
    mod_nb = m;
    ctrl = c;
    wval = v;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_in);
      seen = seen | oe;
      if (i == 3) begin
        mod_nb = 6'h20;
        ctrl = '0;
        wval = 8'hff;
      end
    end
  endtask
  task automatic t_reset;
    chk({6'h00, pc}, 16'h0000);
    chk({oe, pa_oe}, 16'h0000);
  endtask
  task automatic t_load_pc;
    op(6'h02, AD_PC, 8'h5a);
    chk({6'h00, pc}, 16'h025a);
    op(6'h01, AD_IX, 8'h77);
    chk({6'h00, pc}, 16'h025a);
    op(6'h06, AD_PC, 8'h13);
    chk({6'h00, pc}, 16'h025a);
  endtask
  task automatic t_read;
    op(6'h03, RD, 8'hff);
    chk({8'h00, seen}, 16'h00ff);
    op(6'h07, RD, 8'hff);
    chk({8'h00, seen}, 16'h0000);
  endtask
  task automatic t_ports;
    op(6'h30, WR, 8'h3c);
    chk({pa_oe, pb_oe}, 16'hc300);
    op(6'h31, WR, 8'h81);
    chk({pa_oe, pb_oe}, 16'hc37e);
    ext_a = 8'h0f;
    op(6'h30, RD, 8'hff);
    chk({8'h00, seen}, 16'h00f3);
    ext_a = 8'hff;
  endtask
  task automatic t_stack;
    logic [4:0] c[8] = '{PUSH, PUSH, PUSH, POP, POP, POP, POP, 5'h03};
    logic [9:0] e[8] = '{10'h011, 10'h122, 10'h233, 10'h122, 10'h011, 10'h25a, 10'h25a, 10'h25b};
    for (int i = 0; i < 8; i++) begin
      op({4'h0, e[i][9:8]}, c[i], e[i][7:0]);
      chk({6'h00, pc}, {6'h00, e[i]});
    end
  endtask
  task automatic results;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    srst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    t_reset();
    t_load_pc();
    t_read();
    t_ports();
    t_stack();
    srst_in = 1'b1;
    repeat (20) @(negedge clk_in);
    srst_in = 1'b0;
    @(negedge clk_in);
    t_reset();
    results();
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    n_mismatch++;
    results();
  end
endmodule

// [testbench/program_store_monitor.sv]
// checker for the program store module ports
// assumes clk_en_in held high by the bench
`timescale 1ns/1ps
module program_store_monitor (
  input wire logic clk_in, // clock
  input wire logic srst_in, // reset
  input wire logic [5:0] module_number_bus_in, // module number
  input wire prog_store_pkg::bus_ctrl_s ctrl_in, // controls
  input wire logic [7:0] data_bus_out, // bus pull value
  input wire logic [7:0] data_bus_oe_out, // bus pull enable
  input wire logic [7:0] port_a_out, // port a value
  input wire logic [7:0] port_a_oe_out, // port a enable
  input wire logic [7:0] port_b_out, // port b value
  input wire logic [9:0] pc_out // counter
);
  default clocking @(posedge clk_in); endclocking
  a_reset_clears: assert property (srst_in |=> pc_out == 10'h000 && data_bus_oe_out == 8'h00)
    else $error("state not cleared by reset");
  a_reset_ports: assert property (srst_in |=> port_a_oe_out == 8'h00)
    else $error("port not released by reset");
  a_pull_low_only: assert property (data_bus_out == 8'h00 && port_a_out == 8'h00 && port_b_out == 8'h00)
    else $error("line driven high");
  a_drive_one_cycle: assert property (disable iff (srst_in) |data_bus_oe_out |=> data_bus_oe_out == 8'h00)
    else $error("bus pull longer than one cycle");
  a_drive_on_read: assert property (disable iff (srst_in) |data_bus_oe_out |->
    $past(ctrl_in.transfer_direction, 3) && $past(ctrl_in.data_or_address_qualifier, 3))
    else $error("bus pulled without a data read");
  a_drive_on_hit: assert property (disable iff (srst_in) |data_bus_oe_out |->
    $past(module_number_bus_in[5:1], 3) inside {5'h00, 5'h01, 5'h18})
    else $error("bus pulled for a foreign module");
  a_port_own_write: assert property (disable iff (srst_in) $changed(port_a_oe_out) |->
    $past(module_number_bus_in, 3) == 6'h30 && !$past(ctrl_in.transfer_direction, 3))
    else $error("port a changed without its write");
  a_pc_on_hit: assert property (disable iff (srst_in) $changed(pc_out) |->
    $past(module_number_bus_in[5:2], 3) == 4'h0)
    else $error("counter moved for a foreign module");
  c_read: cover property (disable iff (srst_in) |data_bus_oe_out);
  c_port: cover property (disable iff (srst_in) $changed(port_a_oe_out));
  c_pc: cover property (disable iff (srst_in) $changed(pc_out));
endmodule
bind program_store_module program_store_monitor mon_u (.clk_in, .srst_in, .module_number_bus_in, .ctrl_in,
  .data_bus_out, .data_bus_oe_out, .port_a_out, .port_a_oe_out, .port_b_out, .pc_out);
